/* File: lvd_pkg.sv */
// constants of the supply drop detector control block
// assumes an 8-bit cpu data bus with 16-bit addresses
package lvd_pkg;
    localparam logic [15:0] ADDR_CTRL = 16'hffbe;
    localparam logic [15:0] ADDR_LEVEL = 16'hffbf;
    localparam logic [15:0] ADDR_IRQ_REQ = 16'hffe0;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hffe4;
    localparam logic [15:0] ADDR_RESET_CAUSE = 16'hffa8;
    localparam int BIT_CMP_EN = 7;
    localparam int BIT_REF_EN = 4;
    localparam int BIT_RESP_SEL = 1;
    localparam int BIT_FLAG = 0;
    localparam int BIT_IRQ = 0;
    localparam int BIT_CAUSE = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam logic [2:0] LEVEL_FORBIDDEN = 3'h7;
    localparam logic [2:0] LEVEL_PON_LOW = 3'h4;
    localparam logic MASK_RESET = 1'b1;
    // software settling waits, for driver code only
    localparam int CLK_MHZ = 40;
    localparam int REF_WAIT_US = 2000;
    localparam int CMP_WAIT_US = 200;
    localparam int REF_WAIT_CYC = REF_WAIT_US * CLK_MHZ;
    localparam int CMP_WAIT_CYC = CMP_WAIT_US * CLK_MHZ;
endpackage : lvd_pkg

/* File: lvd_sync_if.sv */
// carrier between the top and the comparator synchroniser
// assumes both ends run on mclk
`timescale 1ns/1ps
interface lvd_sync_if;
    logic raw;
    logic synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface : lvd_sync_if

/* File: lvd_sync.sv */
// two-stage synchroniser for the asynchronous comparator output
// assumes raw may change at any time
`timescale 1ns/1ps
module lvd_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // carrier
    lvd_sync_if.sync port_if
);
    logic stage1;
    logic stage2;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= port_if.raw;
            stage2 <= stage1;
        end
    end

    assign port_if.synced = stage2;
endmodule : lvd_sync

/* File: lvd_ctrl.sv */
// control logic of the on-chip supply drop detector
// assumes the cpu makes one-cycle read and write strobes on mclk,
// the comparator output is asynchronous, other reset sources are on mclk
`timescale 1ns/1ps

module lvd_ctrl import lvd_pkg::*; #(
    parameter bit PON_FITTED = 1'b0,
    parameter bit PON_HIGH = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // cpu register port
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_bit_wr,
    input wire logic [2:0] bus_bit_idx,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // other reset sources
    input wire logic other_reset,
    input wire logic pon_reset,
    // analog detector
    input wire logic cmp_below_raw,
    output logic [2:0] level_code,
    output logic ref_gen_enable,
    output logic cmp_enable,
    // system outputs
    output logic undervoltage_irq,
    output logic lvd_reset_out
);
    logic comparator_enable;
    logic reference_enable;
    logic response_select;
    logic irq_request;
    logic irq_mask;
    logic reset_cause;
    logic irq_src_q;

    ////////////////////////////////////////////////////////////////////
    // comparator synchroniser

    lvd_sync_if sync_if ();
    assign sync_if.raw = cmp_below_raw;
    lvd_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .port_if(sync_if)
    );

    ////////////////////////////////////////////////////////////////////
    // decode

    wire sel_ctrl = bus_addr == ADDR_CTRL;
    wire sel_level = bus_addr == ADDR_LEVEL;
    wire sel_req = bus_addr == ADDR_IRQ_REQ;
    wire sel_mask = bus_addr == ADDR_IRQ_MASK;
    wire sel_cause = bus_addr == ADDR_RESET_CAUSE;
    // a bit write carries its value in bus_wdata[0]
    wire [7:0] bit_onehot = 8'h01 << bus_bit_idx;
    wire [7:0] ctrl_now = {comparator_enable, 2'b00, reference_enable,
                           2'b00, response_select, 1'b0};
    wire [7:0] bit_merge = bus_wdata[0] ? (ctrl_now | bit_onehot)
                                        : (ctrl_now & ~bit_onehot);
    wire ctrl_we = sel_ctrl && (bus_wr || bus_bit_wr);
    wire [7:0] ctrl_wval = bus_wr ? bus_wdata : bit_merge;
    wire level_we = sel_level && bus_wr
                    && bus_wdata[2:0] != LEVEL_FORBIDDEN;
    wire bit0_wr = bus_bit_wr && bus_bit_idx == 3'h0;
    wire req_we = sel_req && (bus_wr || bit0_wr);
    wire mask_we = sel_mask && (bus_wr || bit0_wr);
    wire cause_rd = sel_cause && bus_rd;
    // control bits clear on any reset except the detector's own
    wire ctrl_clear = other_reset || pon_reset;

    ////////////////////////////////////////////////////////////////////
    // detection

    wire flag = sync_if.synced && comparator_enable;
    wire irq_src = flag && !response_select;
    wire next_lvd_reset = flag && response_select;
    wire irq_set = irq_src && !irq_src_q;
    wire pon_masks = PON_FITTED && PON_HIGH
                     && level_code >= LEVEL_PON_LOW;

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            comparator_enable <= 1'b0;
            reference_enable <= 1'b0;
            response_select <= 1'b0;
        end else if (ctrl_clear) begin
            comparator_enable <= 1'b0;
            reference_enable <= 1'b0;
            response_select <= 1'b0;
        end else if (ctrl_we) begin
            comparator_enable <= ctrl_wval[BIT_CMP_EN];
            reference_enable <= ctrl_wval[BIT_REF_EN];
            response_select <= ctrl_wval[BIT_RESP_SEL];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_code <= LEVEL_RESET;
            irq_mask <= MASK_RESET;
        end else begin
            if (level_we)
                level_code <= bus_wdata[2:0];
            if (mask_we)
                irq_mask <= bus_wdata[0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_src_q <= 1'b0;
            irq_request <= 1'b0;
            reset_cause <= 1'b0;
        end else begin
            irq_src_q <= irq_src;
            irq_request <= irq_set || (req_we ? bus_wdata[0] : irq_request);
            if (lvd_reset_out)
                reset_cause <= 1'b1;
            else if (pon_reset || cause_rd)
                reset_cause <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs and read port

    wire [7:0] rd_ctrl = ctrl_now | {7'h00, flag};
    wire [7:0] rd_mux = sel_ctrl ? rd_ctrl :
                        sel_level ? {5'h00, level_code} :
                        sel_req ? {7'h00, irq_request} :
                        sel_mask ? {7'h00, irq_mask} :
                        sel_cause ? {7'h00, reset_cause} : RESET_BYTE;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_rdata <= RESET_BYTE;
            ref_gen_enable <= PON_FITTED;
            cmp_enable <= 1'b0;
            undervoltage_irq <= 1'b0;
            lvd_reset_out <= 1'b0;
        end else begin
            bus_rdata <= bus_rd ? rd_mux : RESET_BYTE;
            ref_gen_enable <= PON_FITTED || reference_enable;
            cmp_enable <= comparator_enable;
            undervoltage_irq <= irq_request && !irq_mask;
            lvd_reset_out <= next_lvd_reset && !(pon_masks && pon_reset);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    level_write_a: assert property (level_we |=>
        level_code == $past(bus_wdata[2:0]))
        else $error("level code not stored");
    level_forbid_a: assert property (
        level_code != LEVEL_FORBIDDEN)
        else $error("forbidden level code held");
    reset_mode_a: assert property (
        (flag && response_select && !pon_reset) |=> lvd_reset_out)
        else $error("no reset below level");
    // mask may move in the request cycle, so use its old value
    irq_mode_a: assert property (
        irq_set |=> irq_request ##1 (undervoltage_irq == !$past(irq_mask)))
        else $error("request not raised");
    no_spurious_a: assert property (
        !sync_if.synced |=> !lvd_reset_out)
        else $error("reset while above level");
    mask_gate_a: assert property (
        undervoltage_irq |-> !$past(irq_mask))
        else $error("interrupt passed mask");
    cause_set_a: assert property (
        lvd_reset_out |=> reset_cause)
        else $error("cause bit not set");
    cause_keep_a: assert property (
        (reset_cause && !pon_reset && !cause_rd) |=> reset_cause)
        else $error("cause lost to other reset");
    irq_route_a: assert property (
        (response_select && !irq_request && !req_we) |=> !irq_request)
        else $error("interrupt in reset mode");
    ctrl_keep_a: assert property (
        (lvd_reset_out && !ctrl_clear && !ctrl_we) |=> $stable(ctrl_now))
        else $error("control lost on own reset");
    ctrl_clear_a: assert property (
        ctrl_clear |=> ctrl_now == RESET_BYTE)
        else $error("control kept on other reset");
    ref_fixed_a: assert property (
        1'b1 |=> ref_gen_enable == (PON_FITTED || $past(reference_enable)))
        else $error("reference enable wrong");
    sync_lat_a: assert property (
        comparator_enable [*3] |-> flag == $past(cmp_below_raw, 2))
        else $error("synchroniser depth wrong");

    reset_seen_c: cover property (response_select ##1 lvd_reset_out);
    irq_seen_c: cover property (irq_set ##2 undervoltage_irq);
    cause_read_c: cover property (reset_cause ##1 cause_rd);
    ctrl_clear_c: cover property (ctrl_clear && reset_cause);
    bit_stop_c: cover property (bus_bit_wr && sel_ctrl && !comparator_enable);
endmodule : lvd_ctrl

/* File: low_voltage_detector_ctrl_tb.sv */
// testbench of the supply drop detector control block
// assumes lvd_ctrl with default parameters; inputs move at negedge
`timescale 1ns/1ps
module low_voltage_detector_ctrl_tb import lvd_pkg::*; ;
logic mclk = 1'b0;
logic rst = 1'b1;
logic [15:0] bus_addr = 16'h0000;
logic [7:0] bus_wdata = 8'h00;
logic bus_wr = 1'b0;
logic bus_bit_wr = 1'b0;
logic [2:0] bus_bit_idx = 3'h0;
logic bus_rd = 1'b0;
logic other_reset = 1'b0;
logic pon_reset = 1'b0;
logic cmp_below_raw = 1'b0;
logic [7:0] bus_rdata;
logic [2:0] level_code;
logic ref_gen_enable, cmp_enable, undervoltage_irq, lvd_reset_out;
int n_mismatch = 0;
int check_count = 0;
logic [31:0] seed = 32'h07a6e299;
logic [7:0] rv, lv;

always #12.5 mclk = ~mclk;

lvd_ctrl DUT (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr),
    .bus_bit_idx(bus_bit_idx), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .other_reset(other_reset), .pon_reset(pon_reset),
    .cmp_below_raw(cmp_below_raw), .level_code(level_code),
    .ref_gen_enable(ref_gen_enable), .cmp_enable(cmp_enable),
    .undervoltage_irq(undervoltage_irq), .lvd_reset_out(lvd_reset_out));

////////////////////////////////////////////////////////////////////////
function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
endfunction : xs

// control register image from its field values
function logic [7:0] ctrl_exp(input logic c, input logic r,
                              input logic m, input logic f);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_CMP_EN] = c;
    v[BIT_REF_EN] = r;
    v[BIT_RESP_SEL] = m;
    v[BIT_FLAG] = f;
    return v;
endfunction : ctrl_exp

task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask : chk

task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge mclk);
    bus_wr = 1'b0;
endtask : wr

task bwr(input logic [15:0] a, input logic [2:0] idx, input logic v);
    @(negedge mclk);
    bus_addr = a;
    bus_bit_idx = idx;
    bus_wdata = {7'h00, v};
    bus_bit_wr = 1'b1;
    @(negedge mclk);
    bus_bit_wr = 1'b0;
endtask : bwr

task rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge mclk);
    bus_rd = 1'b0;
    d = bus_rdata;
endtask : rd

task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask : close_out

////////////////////////////////////////////////////////////////////////
initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    rd(ADDR_LEVEL, rv);
    chk(rv, {5'h00, LEVEL_RESET});
    rd(ADDR_IRQ_MASK, rv);
    chk(rv, {7'h00, MASK_RESET});
    rd(ADDR_CTRL, rv);
    chk(rv, ctrl_exp(1'b0, 1'b0, 1'b0, 1'b0));
    $display("reset values done");
    // corners 0 and 6, then random legal codes
    for (int i = 0; i < 10; i++) begin
        seed = xs(seed);
        lv = (i == 0) ? 8'h00 : (i == 1) ? 8'h06 : {5'h00, seed[2:0] % 3'h7};
        wr(ADDR_LEVEL, lv);
        chk({5'h00, level_code}, lv);
        rd(ADDR_LEVEL, rv);
        chk(rv, lv);
    end
    wr(ADDR_LEVEL, {5'h00, LEVEL_FORBIDDEN});
    chk({5'h00, level_code}, lv);
    bwr(ADDR_LEVEL, 3'h0, ~lv[0]);
    chk({5'h00, level_code}, lv);
    $display("level codes done");
    bwr(ADDR_CTRL, 3'(BIT_REF_EN), 1'b1);
    // the pin follows the register one edge later
    @(negedge mclk);
    chk({7'h00, ref_gen_enable}, 8'h01);
    cmp_below_raw = 1'b1;
    repeat (6) @(negedge mclk);
    rd(ADDR_IRQ_REQ, rv);
    chk(rv, 8'h00);
    bwr(ADDR_CTRL, 3'(BIT_CMP_EN), 1'b1);
    repeat (5) @(negedge mclk);
    rd(ADDR_CTRL, rv);
    chk(rv, ctrl_exp(1'b1, 1'b1, 1'b0, 1'b1));
    chk({7'h00, undervoltage_irq}, 8'h00);
    rd(ADDR_IRQ_REQ, rv);
    chk(rv, 8'h01);
    bwr(ADDR_IRQ_MASK, 3'h0, 1'b0);
    repeat (2) @(negedge mclk);
    chk({7'h00, undervoltage_irq}, 8'h01);
    cmp_below_raw = 1'b0;
    bwr(ADDR_IRQ_REQ, 3'h0, 1'b0);
    repeat (2) @(negedge mclk);
    chk({7'h00, undervoltage_irq}, 8'h00);
    $display("interrupt mode done");
    bwr(ADDR_IRQ_MASK, 3'h0, 1'b1);
    bwr(ADDR_CTRL, 3'(BIT_RESP_SEL), 1'b1);
    repeat (4) @(negedge mclk);
    chk({7'h00, lvd_reset_out}, 8'h00);
    rd(ADDR_CTRL, rv);
    chk(rv, ctrl_exp(1'b1, 1'b1, 1'b1, 1'b0));
    cmp_below_raw = 1'b1;
    repeat (4) @(negedge mclk);
    chk({7'h00, lvd_reset_out}, 8'h01);
    rd(ADDR_IRQ_REQ, rv);
    chk(rv, 8'h00);
    rd(ADDR_CTRL, rv);
    chk(rv, ctrl_exp(1'b1, 1'b1, 1'b1, 1'b1));
    cmp_below_raw = 1'b0;
    repeat (4) @(negedge mclk);
    chk({7'h00, lvd_reset_out}, 8'h00);
    other_reset = 1'b1;
    @(negedge mclk);
    other_reset = 1'b0;
    rd(ADDR_CTRL, rv);
    chk(rv, 8'h00);
    rd(ADDR_RESET_CAUSE, rv);
    chk(rv, 8'h01);
    rd(ADDR_RESET_CAUSE, rv);
    chk(rv, 8'h00);
    wr(ADDR_CTRL, ctrl_exp(1'b1, 1'b1, 1'b1, 1'b0));
    wr(ADDR_CTRL, RESET_BYTE);
    @(negedge mclk);
    chk({7'h00, cmp_enable}, 8'h00);
    rd(ADDR_CTRL, rv);
    chk(rv, 8'h00);
    $display("reset mode done");
    // detector reset, then a power-on clear wipes cause and control
    wr(ADDR_CTRL, ctrl_exp(1'b1, 1'b1, 1'b1, 1'b0));
    cmp_below_raw = 1'b1;
    repeat (4) @(negedge mclk);
    chk({7'h00, lvd_reset_out}, 8'h01);
    cmp_below_raw = 1'b0;
    repeat (4) @(negedge mclk);
    pon_reset = 1'b1;
    @(negedge mclk);
    pon_reset = 1'b0;
    rd(ADDR_CTRL, rv);
    chk(rv, 8'h00);
    rd(ADDR_RESET_CAUSE, rv);
    chk(rv, 8'h00);
    $display("power-on clear done");
    // interrupt mode stopped by single-bit writes
    wr(ADDR_CTRL, ctrl_exp(1'b1, 1'b1, 1'b0, 1'b0));
    bwr(ADDR_CTRL, 3'(BIT_CMP_EN), 1'b0);
    rd(ADDR_CTRL, rv);
    chk(rv, ctrl_exp(1'b0, 1'b1, 1'b0, 1'b0));
    bwr(ADDR_CTRL, 3'(BIT_REF_EN), 1'b0);
    rd(ADDR_CTRL, rv);
    chk(rv, ctrl_exp(1'b0, 1'b0, 1'b0, 1'b0));
    chk({7'h00, ref_gen_enable}, 8'h00);
    $display("bit stop done");
    close_out();
end

// cuts a hang short
initial begin
    #(25 * 3000);
    n_mismatch++;
    close_out();
end
endmodule : low_voltage_detector_ctrl_tb
